// [int_ops_unit.v]
// execute logic and apb registers for the interrupt instruction group
//
// How it works
// - opcode 0x004 clears global interrupt enable
// - opcode 0x005 sets global interrupt enable
// - 0x038, enable bit 0: flag set skips, clears
// - 0x038, enable bit 1: acts as nop
// - ext0 enable bit is control one bit 0
// - 0x03a, select 1: skip when pin high
// - 0x03a, select 0: skip when pin low
// - pin select bit is control three bit 2
// - 0x054 copies control one to accumulator
// - 0x03f loads control one from accumulator
// - 0x055 copies control two to accumulator
// - 0x03e loads control two from accumulator
// - 0x253 copies control three to accumulator
// - 0x217 loads control three from accumulator
`timescale 1ns/1ps
`include "int_ops_map.vh"

module int_ops_unit (
    input  wire                   clk,
    input  wire                   rst,
    // instruction side
    input  wire                   exec_valid,
    input  wire [`OP_W-1:0]       opcode,
    input  wire [`NIB_W-1:0]      acc_in,
    input  wire                   int_pin,
    input  wire                   ext0_event,
    output reg                    acc_load,
    output reg  [`NIB_W-1:0]      acc_out,
    output reg                    skip_next,
    output reg                    global_irq_enable_flag,
    output reg                    ext0_request_flag,
    output reg  [`NIB_W-1:0]      int_ctrl_reg_one,
    output reg  [`NIB_W-1:0]      int_ctrl_reg_two,
    output reg  [`NIB_W-1:0]      int_ctrl_reg_three,
    // apb slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`APB_ADDR_W-1:0] paddr,
    input  wire [`APB_DATA_W-1:0] pwdata,
    output reg                    pready,
    output reg  [`APB_DATA_W-1:0] prdata,
    output reg                    pslverr
);

// ==========================================================
// decode
wire irq_disable_op;
wire irq_enable_op;
wire skip_on_ext0_request_op;
wire skip_on_pin_level_op;
wire read_int_ctrl_one_op;
wire write_int_ctrl_one_op;
wire read_int_ctrl_two_op;
wire write_int_ctrl_two_op;
wire read_int_ctrl_three_op;
wire write_int_ctrl_three_op;

int_ops_decode u_decode (
    .opcode                  (opcode),
    .valid                   (exec_valid),
    .irq_disable_op          (irq_disable_op),
    .irq_enable_op           (irq_enable_op),
    .skip_on_ext0_request_op (skip_on_ext0_request_op),
    .skip_on_pin_level_op    (skip_on_pin_level_op),
    .read_int_ctrl_one_op    (read_int_ctrl_one_op),
    .write_int_ctrl_one_op   (write_int_ctrl_one_op),
    .read_int_ctrl_two_op    (read_int_ctrl_two_op),
    .write_int_ctrl_two_op   (write_int_ctrl_two_op),
    .read_int_ctrl_three_op  (read_int_ctrl_three_op),
    .write_int_ctrl_three_op (write_int_ctrl_three_op)
);

// ==========================================================
// field views
wire ext0_enable_bit;
wire pin_level_select_bit;

assign ext0_enable_bit      = int_ctrl_reg_one[`EXT0_ENABLE_BIT];
assign pin_level_select_bit = int_ctrl_reg_three[`PIN_LEVEL_SELECT_BIT];

// ==========================================================
// skip tests
wire ext0_skip;
wire pin_skip;

// enable bit set turns the test into a nop: no skip, no clear
assign ext0_skip = skip_on_ext0_request_op && !ext0_enable_bit
                   && ext0_request_flag;
assign pin_skip  = skip_on_pin_level_op
                   && (int_pin == pin_level_select_bit);

reg next_skip;

// only one opcode is live per cycle, so the two tests never compete
// a skip pulse lasts one cycle; the sequencer drops the next fetch
always @* begin
    next_skip = 1'b0;
    if (ext0_skip) begin
        next_skip = 1'b1;
    end
    if (pin_skip) begin
        next_skip = 1'b1;
    end
end

// ==========================================================
// apb phase decode
wire       apb_done;
wire       apb_wr;
wire       addr_hit;
wire       wr_ctrl_one;
wire       wr_ctrl_two;
wire       wr_ctrl_three;
wire       wr_status;

// a write lands only on the edge at which the master sees pready
assign apb_done      = psel && penable && pready;
assign apb_wr        = apb_done && pwrite;
assign addr_hit      = (paddr == `ADDR_INT_CTRL_ONE)
                       || (paddr == `ADDR_INT_CTRL_TWO)
                       || (paddr == `ADDR_INT_CTRL_THREE)
                       || (paddr == `ADDR_IRQ_STATUS);
assign wr_ctrl_one   = apb_wr && (paddr == `ADDR_INT_CTRL_ONE);
assign wr_ctrl_two   = apb_wr && (paddr == `ADDR_INT_CTRL_TWO);
assign wr_ctrl_three = apb_wr && (paddr == `ADDR_INT_CTRL_THREE);
assign wr_status     = apb_wr && (paddr == `ADDR_IRQ_STATUS);

// ==========================================================
// control register one
reg [`NIB_W-1:0] next_ctrl_one;

// instruction beats software on a same-cycle write
always @* begin
    next_ctrl_one = int_ctrl_reg_one;
    if (write_int_ctrl_one_op) begin
        next_ctrl_one = acc_in;
    end else if (wr_ctrl_one) begin
        next_ctrl_one = pwdata[`NIB_W-1:0];
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        int_ctrl_reg_one <= `CTRL_RESET;
    end else begin
        int_ctrl_reg_one <= next_ctrl_one;
    end
end

// ==========================================================
// control register two
reg [`NIB_W-1:0] next_ctrl_two;

always @* begin
    next_ctrl_two = int_ctrl_reg_two;
    if (write_int_ctrl_two_op) begin
        next_ctrl_two = acc_in;
    end else if (wr_ctrl_two) begin
        next_ctrl_two = pwdata[`NIB_W-1:0];
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        int_ctrl_reg_two <= `CTRL_RESET;
    end else begin
        int_ctrl_reg_two <= next_ctrl_two;
    end
end

// ==========================================================
// control register three
reg [`NIB_W-1:0] next_ctrl_three;

always @* begin
    next_ctrl_three = int_ctrl_reg_three;
    if (write_int_ctrl_three_op) begin
        next_ctrl_three = acc_in;
    end else if (wr_ctrl_three) begin
        next_ctrl_three = pwdata[`NIB_W-1:0];
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        int_ctrl_reg_three <= `CTRL_RESET;
    end else begin
        int_ctrl_reg_three <= next_ctrl_three;
    end
end

// ==========================================================
// global interrupt enable
reg next_irq_enable;

always @* begin
    next_irq_enable = global_irq_enable_flag;
    if (irq_disable_op) begin
        next_irq_enable = 1'b0;
    end else if (irq_enable_op) begin
        next_irq_enable = 1'b1;
    end else if (wr_status) begin
        next_irq_enable = pwdata[`STAT_IRQ_ENABLE_BIT];
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        global_irq_enable_flag <= `FLAG_RESET;
    end else begin
        global_irq_enable_flag <= next_irq_enable;
    end
end

// ==========================================================
// external-0 request flag
reg  next_ext0_flag;
wire ext0_sw_clear;

// software clears by writing one; a request in the same cycle wins
assign ext0_sw_clear = wr_status && pwdata[`STAT_EXT0_FLAG_BIT];

always @* begin
    next_ext0_flag = ext0_request_flag;
    if (ext0_skip || ext0_sw_clear) begin
        next_ext0_flag = 1'b0;
    end
    if (ext0_event) begin
        next_ext0_flag = 1'b1;
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        ext0_request_flag <= `FLAG_RESET;
    end else begin
        ext0_request_flag <= next_ext0_flag;
    end
end

// ==========================================================
// accumulator transfer and skip result
reg              next_acc_load;
reg [`NIB_W-1:0] next_acc_out;

always @* begin
    next_acc_load = 1'b0;
    next_acc_out  = acc_out;
    if (read_int_ctrl_one_op) begin
        next_acc_load = 1'b1;
        next_acc_out  = int_ctrl_reg_one;
    end else if (read_int_ctrl_two_op) begin
        next_acc_load = 1'b1;
        next_acc_out  = int_ctrl_reg_two;
    end else if (read_int_ctrl_three_op) begin
        next_acc_load = 1'b1;
        next_acc_out  = int_ctrl_reg_three;
    end
end

// results are registered so the sequencer sees them one edge later
always @(posedge clk or posedge rst) begin
    if (rst) begin
        acc_load  <= 1'b0;
        acc_out   <= `CTRL_RESET;
        skip_next <= 1'b0;
    end else begin
        acc_load  <= next_acc_load;
        acc_out   <= next_acc_out;
        skip_next <= next_skip;
    end
end

// ==========================================================
// apb read mux
reg [`APB_DATA_W-1:0] rd_word;
// upper data bits read zero; status bits are live, not latched

always @* begin
    rd_word = `APB_ZERO;
    case (paddr)
        `ADDR_INT_CTRL_ONE: begin
            rd_word[`NIB_W-1:0] = int_ctrl_reg_one;
        end
        `ADDR_INT_CTRL_TWO: begin
            rd_word[`NIB_W-1:0] = int_ctrl_reg_two;
        end
        `ADDR_INT_CTRL_THREE: begin
            rd_word[`NIB_W-1:0] = int_ctrl_reg_three;
        end
        `ADDR_IRQ_STATUS: begin
            rd_word[`STAT_IRQ_ENABLE_BIT] = global_irq_enable_flag;
            rd_word[`STAT_EXT0_FLAG_BIT]  = ext0_request_flag;
            rd_word[`STAT_PIN_LEVEL_BIT]  = int_pin;
        end
        default: begin
            rd_word = `APB_ZERO;
        end
    endcase
end

// ==========================================================
// apb answer: one wait state keeps pready, prdata on flops
wire                  apb_access;
wire                  apb_rd_access;
reg                   next_pready;
reg [`APB_DATA_W-1:0] next_prdata;
reg                   next_pslverr;

// pready is built from itself, so it drops once the master has seen it
assign apb_access    = psel && penable && !pready;
assign apb_rd_access = apb_access && !pwrite;

// an unmapped address answers with an error after the same one wait state rather than stall
always @* begin
    next_pready  = apb_access;
    next_prdata  = `APB_ZERO;
    next_pslverr = 1'b0;
    if (apb_access) begin
        next_pslverr = !addr_hit;
    end
    if (apb_rd_access) begin
        next_prdata = rd_word;
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        pready  <= 1'b0;
        prdata  <= `APB_ZERO;
        pslverr <= 1'b0;
    end else begin
        pready  <= next_pready;
        prdata  <= next_prdata;
        pslverr <= next_pslverr;
    end
end

endmodule

// [int_ops_map.vh]
// constants for the interrupt instruction group and its register map
`ifndef INT_OPS_MAP_VH
`define INT_OPS_MAP_VH

// ==========================================================
// instruction word
`define OP_W                     10
`define NIB_W                    4
`define OP_IRQ_DISABLE           10'h004
`define OP_IRQ_ENABLE            10'h005
`define OP_SKIP_EXT0_REQUEST     10'h038
`define OP_SKIP_PIN_LEVEL        10'h03a
`define OP_READ_INT_CTRL_ONE     10'h054
`define OP_WRITE_INT_CTRL_ONE    10'h03f
`define OP_READ_INT_CTRL_TWO     10'h055
`define OP_WRITE_INT_CTRL_TWO    10'h03e
`define OP_READ_INT_CTRL_THREE   10'h253
`define OP_WRITE_INT_CTRL_THREE  10'h217

// ==========================================================
// field positions
`define EXT0_ENABLE_BIT          0
`define PIN_LEVEL_SELECT_BIT     2
`define STAT_IRQ_ENABLE_BIT      0
`define STAT_EXT0_FLAG_BIT       1
`define STAT_PIN_LEVEL_BIT       2

// ==========================================================
// reset values
`define CTRL_RESET               4'h0
`define FLAG_RESET               1'b0

// ==========================================================
// apb register map, byte addresses
`define APB_ADDR_W               8
`define APB_DATA_W               32
`define ADDR_INT_CTRL_ONE        8'h00
`define ADDR_INT_CTRL_TWO        8'h04
`define ADDR_INT_CTRL_THREE      8'h08
`define ADDR_IRQ_STATUS          8'h0c
`define APB_ZERO                 32'h00000000

`endif

// [int_ops_decode.v]
// opcode decoder for the interrupt instruction group
`timescale 1ns/1ps
`include "int_ops_map.vh"

module int_ops_decode (
    input  wire [`OP_W-1:0] opcode,
    input  wire             valid,
    output wire             irq_disable_op,
    output wire             irq_enable_op,
    output wire             skip_on_ext0_request_op,
    output wire             skip_on_pin_level_op,
    output wire             read_int_ctrl_one_op,
    output wire             write_int_ctrl_one_op,
    output wire             read_int_ctrl_two_op,
    output wire             write_int_ctrl_two_op,
    output wire             read_int_ctrl_three_op,
    output wire             write_int_ctrl_three_op
);

// ==========================================================
// full ten-bit compare, no partial decode
assign irq_disable_op          = valid && (opcode == `OP_IRQ_DISABLE);
assign irq_enable_op           = valid && (opcode == `OP_IRQ_ENABLE);
assign skip_on_ext0_request_op = valid && (opcode == `OP_SKIP_EXT0_REQUEST);
assign skip_on_pin_level_op    = valid && (opcode == `OP_SKIP_PIN_LEVEL);
assign read_int_ctrl_one_op    = valid && (opcode == `OP_READ_INT_CTRL_ONE);
assign write_int_ctrl_one_op   = valid && (opcode == `OP_WRITE_INT_CTRL_ONE);
assign read_int_ctrl_two_op    = valid && (opcode == `OP_READ_INT_CTRL_TWO);
assign write_int_ctrl_two_op   = valid && (opcode == `OP_WRITE_INT_CTRL_TWO);
assign read_int_ctrl_three_op  = valid && (opcode == `OP_READ_INT_CTRL_THREE);
assign write_int_ctrl_three_op = valid && (opcode == `OP_WRITE_INT_CTRL_THREE);

endmodule

// [int_ops_props.sv]
// assertion checker for the interrupt instruction unit
`timescale 1ns/1ps
`include "int_ops_map.vh"
module int_ops_props (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              exec_valid,
    input wire logic [`OP_W-1:0]  opcode,
    input wire logic [`NIB_W-1:0] acc_in,
    input wire logic              int_pin,
    input wire logic              ext0_event,
    input wire logic              acc_load,
    input wire logic [`NIB_W-1:0] acc_out,
    input wire logic              skip_next,
    input wire logic              global_irq_enable_flag,
    input wire logic              ext0_request_flag,
    input wire logic [`NIB_W-1:0] int_ctrl_reg_one,
    input wire logic [`NIB_W-1:0] int_ctrl_reg_two,
    input wire logic [`NIB_W-1:0] int_ctrl_reg_three
);
    // 0x3ff is outside the group, so an idle cycle never matches
    wire [`OP_W-1:0] op = exec_valid ? opcode : 10'h3ff;
    wire             en = int_ctrl_reg_one[`EXT0_ENABLE_BIT];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_GIE_CLR: assert property (op == `OP_IRQ_DISABLE |=> !global_irq_enable_flag)
        else $error("enable flag not cleared");
    AST_GIE_SET: assert property (op == `OP_IRQ_ENABLE |=> global_irq_enable_flag)
        else $error("enable flag not set");
    AST_EXT0_SKIP: assert property (op == `OP_SKIP_EXT0_REQUEST && !en
        |=> skip_next == $past(ext0_request_flag)) else $error("flag test skip wrong");
    AST_EXT0_CLR: assert property (op == `OP_SKIP_EXT0_REQUEST && !en && !ext0_event
        |=> !ext0_request_flag) else $error("request flag not cleared");
    AST_EXT0_NOP: assert property (op == `OP_SKIP_EXT0_REQUEST && en |=> !skip_next)
        else $error("flag test not a nop");
    AST_PIN_SKIP: assert property (op == `OP_SKIP_PIN_LEVEL |=> skip_next ==
        ($past(int_pin) == $past(int_ctrl_reg_three[`PIN_LEVEL_SELECT_BIT])))
        else $error("pin test skip wrong");
    AST_RD_ONE: assert property (op == `OP_READ_INT_CTRL_ONE
        |=> acc_load && acc_out == $past(int_ctrl_reg_one)) else $error("read one wrong");
    AST_WR_ONE: assert property (op == `OP_WRITE_INT_CTRL_ONE
        |=> int_ctrl_reg_one == $past(acc_in)) else $error("write one wrong");
    AST_RD_TWO: assert property (op == `OP_READ_INT_CTRL_TWO
        |=> acc_load && acc_out == $past(int_ctrl_reg_two)) else $error("read two wrong");
    AST_WR_TWO: assert property (op == `OP_WRITE_INT_CTRL_TWO
        |=> int_ctrl_reg_two == $past(acc_in)) else $error("write two wrong");
    AST_RD_THREE: assert property (op == `OP_READ_INT_CTRL_THREE
        |=> acc_load && acc_out == $past(int_ctrl_reg_three)) else $error("read three wrong");
    AST_WR_THREE: assert property (op == `OP_WRITE_INT_CTRL_THREE
        |=> int_ctrl_reg_three == $past(acc_in)) else $error("write three wrong");
endmodule
bind int_ops_unit int_ops_props u_int_ops_props (
    .clk(clk), .rst(rst), .exec_valid(exec_valid), .opcode(opcode), .acc_in(acc_in),
    .int_pin(int_pin), .ext0_event(ext0_event), .acc_load(acc_load), .acc_out(acc_out),
    .skip_next(skip_next), .global_irq_enable_flag(global_irq_enable_flag),
    .ext0_request_flag(ext0_request_flag), .int_ctrl_reg_one(int_ctrl_reg_one),
    .int_ctrl_reg_two(int_ctrl_reg_two), .int_ctrl_reg_three(int_ctrl_reg_three)
);

// [core_seq_model.sv]
// behavioural instruction sequencer that feeds the interrupt unit
`timescale 1ns/1ps
`include "int_ops_map.vh"
module core_seq_model (
    input  wire logic              clk,
    input  wire logic              acc_load,
    input  wire logic [`NIB_W-1:0] acc_out,
    input  wire logic              skip_next,
    output logic                   exec_valid,
    output logic [`OP_W-1:0]       opcode,
    output logic [`NIB_W-1:0]      acc_in
);
    logic [`NIB_W-1:0] acc;
    int                skips;
    initial begin
        exec_valid = 1'b0;
        opcode = 10'h000;
        acc_in = 4'h0;
        acc = 4'h0;
        skips = 0;
    end
    // accumulator and skip bookkeeping as the real sequencer would see them
    always @(posedge clk) begin
        if (acc_load === 1'b1)
            acc <= acc_out;
        if (skip_next === 1'b1)
            skips <= skips + 1;
    end
    // one instruction, then idle so the result can be read mid-cycle
    task automatic issue(input logic [`OP_W-1:0] op, input logic [`NIB_W-1:0] a);
        @(posedge clk);
        exec_valid <= 1'b1;
        opcode <= op;
        acc_in <= a;
        @(posedge clk);
        exec_valid <= 1'b0;
        @(negedge clk);
    endtask
endmodule

// [test_interrupt_instruction_group.sv]
// self-checking bench for the interrupt instruction unit
`timescale 1ns/1ps
`include "int_ops_map.vh"
module test_interrupt_instruction_group;
    logic                    clk, rst, int_pin, ext0_event, psel, penable, pwrite, pready;
    logic                    pslverr, err, exec_valid, acc_load, skip_next, gie, ext0_flag;
    logic [`APB_ADDR_W-1:0]  paddr;
    logic [`APB_DATA_W-1:0]  pwdata, prdata, rd;
    logic [`OP_W-1:0]        opcode;
    logic [`NIB_W-1:0]       acc_in, acc_out;
    logic [`NIB_W-1:0]       ctrl [3];
    logic [`OP_W-1:0]        wr_op [3] = '{`OP_WRITE_INT_CTRL_ONE, `OP_WRITE_INT_CTRL_TWO,
                                          `OP_WRITE_INT_CTRL_THREE};
    logic [`OP_W-1:0]        rd_op [3] = '{`OP_READ_INT_CTRL_ONE, `OP_READ_INT_CTRL_TWO,
                                          `OP_READ_INT_CTRL_THREE};
    logic [`NIB_W-1:0]       val [3] = '{4'h9, 4'h6, 4'hb};
    int                      bad_count, checks, i;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    int_ops_unit u_int_ops_unit (
        .clk(clk), .rst(rst), .exec_valid(exec_valid), .opcode(opcode), .acc_in(acc_in),
        .int_pin(int_pin), .ext0_event(ext0_event), .acc_load(acc_load), .acc_out(acc_out),
        .skip_next(skip_next), .global_irq_enable_flag(gie), .ext0_request_flag(ext0_flag),
        .int_ctrl_reg_one(ctrl[0]), .int_ctrl_reg_two(ctrl[1]), .int_ctrl_reg_three(ctrl[2]),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr)
    );
    core_seq_model u_core_seq_model (
        .clk(clk), .acc_load(acc_load), .acc_out(acc_out), .skip_next(skip_next),
        .exec_valid(exec_valid), .opcode(opcode), .acc_in(acc_in)
    );
    // ==========================================================
    // tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // poll pready, then check the wait was two edges; a slave that never answers is left to the watchdog
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk("apb_wait", 32'h2, n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ex(input logic [`OP_W-1:0] o, input logic [`NIB_W-1:0] a);
        u_core_seq_model.issue(o, a);
    endtask
    task automatic pulse_event;
        @(posedge clk);
        ext0_event <= 1'b1;
        @(posedge clk);
        ext0_event <= 1'b0;
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end
    // ==========================================================
    // tests
    initial begin
        rst = 1'b1;
        int_pin = 1'b0;
        ext0_event = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk("reset", 14'h0, {gie, ext0_flag, ctrl[0], ctrl[1], ctrl[2]});
        ex(`OP_IRQ_ENABLE, 4'h0);
        chk("gie", 1'b1, gie);
        ex(`OP_IRQ_DISABLE, 4'h0);
        chk("gie", 1'b0, gie);
        for (i = 0; i < 3; i++) begin
            ex(wr_op[i], val[i]);
            chk("ctrl", val[i], ctrl[i]);
            ex(rd_op[i], 4'h0);
            chk("acc_load", 1'b1, acc_load);
            chk("acc_out", val[i], acc_out);
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("prdata", val[i], rd);
            chk("pslverr", 1'b0, err);
            chk("acc", val[i], u_core_seq_model.acc);
        end
        // bit 0 low arms the flag test, other bits set to catch a wrong bit
        ex(`OP_WRITE_INT_CTRL_ONE, 4'he);
        pulse_event();
        ex(`OP_SKIP_EXT0_REQUEST, 4'h0);
        chk("skip", 1'b1, skip_next);
        chk("ext0", 1'b0, ext0_flag);
        ex(`OP_SKIP_EXT0_REQUEST, 4'h0);
        chk("skip", 1'b0, skip_next);
        ex(`OP_WRITE_INT_CTRL_ONE, 4'h1);
        pulse_event();
        ex(`OP_SKIP_EXT0_REQUEST, 4'h0);
        chk("skip", 1'b0, skip_next);
        chk("ext0", 1'b1, ext0_flag);
        apb(1'b1, `ADDR_IRQ_STATUS, 32'h2);
        @(negedge clk);
        chk("ext0", 1'b0, ext0_flag);
        apb(1'b0, 8'h10, 32'h0);
        chk("pslverr", 1'b1, err);
        chk("prdata", 32'h0, rd);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            int_pin <= i[0];
            ex(`OP_WRITE_INT_CTRL_THREE, {1'b0, i[1], 2'b00});
            ex(`OP_SKIP_PIN_LEVEL, 4'h0);
            chk("skip", i[0] == i[1], skip_next);
        end
        ex(`OP_IRQ_ENABLE, 4'h0);
        apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
        chk("status", 32'h5, rd);
        apb(1'b1, `ADDR_IRQ_STATUS, 32'h0);
        @(negedge clk);
        chk("gie", 1'b0, gie);
        ex(10'h000, 4'h7);
        chk("foreign", 2'b00, {acc_load, skip_next});
        chk("skips", 32'h3, u_core_seq_model.skips);
        report_and_stop;
    end
endmodule
